// ---- core/adcrs_dev.sv ----
// The implementer's own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "adcrs_params.svh"
// Summary of operation
// R1: overrange single-ended input clamps to 0x3FF
// R2: software discards first result after reference change
// R3: software prepares converter before sleep conversion
// R4: halt in idle or quiet sleep starts conversion
// R5: completion interrupt wakes core, runs handler
// R6: completion interrupt raised even after other wake
// R7: core stays awake until next sleep request
// R8: other sleep states leave converter powered
// R9: software recycles enable for valid differential
// R10: digital pins stay still during conversion
// R11: result bytes hold value once done set
// R12: single-ended code is unsigned 0 to 0x3FF
// R13: differential code two's complement 0x200..0x1FF
// R14: result bit 9 is differential sign
// R15: left-align bit selects justification
// R16: justification change shows immediately
// R17: left: high bits 9..2, low bits 1..0 top
// R18: right: low bits 7..0, high bits 9..8
module adcrs_dev
  import adcrs_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rstn,
  // analog front end, already scaled
  input  wire logic [10:0] sample_se,
  input  wire logic [10:0] sample_diff,
  // status towards user
  output logic             powered,
  // core side
  adcrs_if.dev             link
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  adcrs_conv_t st_r, st_nxt;       // sequencer
  logic        on_r, on_nxt;       // converter_on_bit
  logic        first_r, first_nxt; // next conversion is extended
  logic        ien_r, ien_nxt;     // completion interrupt enable (ctrl)
  logic        left_r, left_nxt;   // left_align_bit
  logic        diff_r, diff_nxt;   // differential channel chosen
  logic [4:0]  cnt_r, cnt_nxt;     // cycles left in conversion
  logic [9:0]  res_r, res_nxt;     // raw 10-bit result
  logic [1:0]  stat_r, stat_nxt;   // sticky events
  logic [1:0]  en_r, en_nxt;       // interrupt enables
  logic [7:0]  rd_r, rd_nxt;       // read data
  logic        halt_d_r, halt_d_nxt; // halted seen last cycle
  logic        wr_ctrl;            // write to control
  logic        start_sw;           // software start
  logic        start_slp;          // sleep start
  logic        finish;             // conversion ends now
  logic [1:0]  clr;                // clear bits this cycle
  logic [15:0] fmt;                // presented result bytes

  // ----------------------------------------
  // functions
  // ----------------------------------------
  // place the 10-bit result in the two bytes
  function automatic logic [15:0] place(input logic [9:0] r, input logic left);
    if (left) begin
      place = {r, 6'h00};                         // [R15] [R17]
    end else begin
      place = {6'h00, r};                         // [R15] [R18]
    end
  endfunction

  // clamp the sampled value to the legal code range
  function automatic logic [9:0] clamp(input logic [10:0] se, input logic [10:0] df, input logic d);
    if (d) begin
      // signed 11-bit difference into 10-bit two's complement
      if (!df[10] && df > `ADCRS_DIFF_MAX) begin
        clamp = 10'(`ADCRS_DIFF_MAX);             // [R13]
      end else if (df[10] && df < `ADCRS_DIFF_MIN) begin
        clamp = 10'h200;                          // [R13]
      end else begin
        clamp = df[9:0];                          // [R13] [R14]
      end
    end else begin
      if (se > `ADCRS_FULL_SE) begin
        clamp = 10'h3ff;                          // [R1]
      end else begin
        clamp = se[9:0];                          // [R12]
      end
    end
  endfunction

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    st_nxt     = st_r;
    on_nxt     = on_r;
    first_nxt  = first_r;
    ien_nxt    = ien_r;
    left_nxt   = left_r;
    diff_nxt   = diff_r;
    cnt_nxt    = cnt_r;
    res_nxt    = res_r;
    en_nxt     = en_r;
    halt_d_nxt = link.halted;
    clr        = 2'h0;
    wr_ctrl    = link.wr && link.addr == `ADCRS_A_CTRL;
    start_sw   = 1'b0;
    start_slp  = 1'b0;
    finish     = 1'b0;
    // register writes
    if (wr_ctrl) begin
      on_nxt  = link.wdata[`ADCRS_B_ON];
      ien_nxt = link.wdata[3];
      if (link.wdata[`ADCRS_B_ON] && !on_r) begin
        first_nxt = 1'b1;
      end
      if (link.wdata[`ADCRS_B_DONE]) begin
        clr[`ADCRS_S_DONE] = 1'b1;
      end
      start_sw = link.wdata[`ADCRS_B_START] && link.wdata[`ADCRS_B_ON];
    end
    if (link.wr && link.addr == `ADCRS_A_CFG) begin
      left_nxt = link.wdata[`ADCRS_B_LEFT];       // [R16]
      diff_nxt = link.wdata[`ADCRS_B_DIFF];
    end
    if (link.wr && link.addr == `ADCRS_A_CLR) begin
      clr = clr | link.wdata[1:0];
    end
    if (link.wr && link.addr == `ADCRS_A_IEN) begin
      en_nxt = link.wdata[1:0];
    end
    // start on the halt edge in idle or quiet sleep only
    start_slp = link.halted && !halt_d_r && on_r
             && (link.sleep_mode == ADCRS_IDLE || link.sleep_mode == ADCRS_QUIET); // [R4] [R8]
    // sequencer
    unique case (st_r)
      ADCRS_WAIT: begin
        if (start_sw || start_slp) begin
          st_nxt    = ADCRS_CONV;
          cnt_nxt   = first_nxt ? `ADCRS_FIRST_CYC : `ADCRS_CONV_CYC;
          first_nxt = 1'b0;
        end
      end
      ADCRS_CONV: begin
        if (wr_ctrl && !link.wdata[`ADCRS_B_ON]) begin
          st_nxt = ADCRS_WAIT;                    // switched off: abort
        end else if (cnt_r == 5'h01) begin
          st_nxt  = ADCRS_WAIT;
          finish  = 1'b1;
          res_nxt = clamp(sample_se, sample_diff, diff_r); // [R11]
        end else begin
          cnt_nxt = cnt_r - 5'h01;
        end
      end
    endcase
    // sticky events; a set wins over a clear
    stat_nxt = stat_r & ~clr;
    if (finish) begin
      stat_nxt[`ADCRS_S_DONE] = 1'b1;             // [R5] [R6] [R11]
    end
    if (start_slp && st_r == ADCRS_WAIT) begin
      stat_nxt[`ADCRS_S_SLEEP] = 1'b1;            // [R4]
    end
    // read mux, data the cycle after the strobe
    fmt   = place(res_r, left_r);                 // [R16]
    rd_nxt = `ADCRS_RST_BYTE;
    if (link.rd) begin
      unique case (link.addr)
        `ADCRS_A_CTRL: rd_nxt = {on_r, st_r == ADCRS_CONV, 1'b0, stat_r[`ADCRS_S_DONE], ien_r, 3'h0};
        `ADCRS_A_CFG:  rd_nxt = {2'h0, left_r, 4'h0, diff_r};
        `ADCRS_A_RESL: rd_nxt = fmt[7:0];         // [R11] [R17] [R18]
        `ADCRS_A_RESH: rd_nxt = fmt[15:8];        // [R11] [R14]
        `ADCRS_A_STAT: rd_nxt = {6'h00, stat_r};
        `ADCRS_A_IEN:  rd_nxt = {6'h00, en_r};
        default:       rd_nxt = `ADCRS_RST_BYTE;  // clear register and unmapped
      endcase
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_r     <= ADCRS_WAIT;
      on_r     <= 1'b0;
      first_r  <= 1'b0;
      ien_r    <= 1'b0;
      left_r   <= 1'b0;
      diff_r   <= 1'b0;
      cnt_r    <= 5'h00;
      res_r    <= 10'h000;
      stat_r   <= `ADCRS_RST_STAT;
      en_r     <= `ADCRS_RST_STAT;
      rd_r     <= `ADCRS_RST_BYTE;
      halt_d_r <= 1'b0;
    end else begin
      st_r     <= st_nxt;
      on_r     <= on_nxt;
      first_r  <= first_nxt;
      ien_r    <= ien_nxt;
      left_r   <= left_nxt;
      diff_r   <= diff_nxt;
      cnt_r    <= cnt_nxt;
      res_r    <= res_nxt;
      stat_r   <= stat_nxt;
      en_r     <= en_nxt;
      rd_r     <= rd_nxt;
      halt_d_r <= halt_d_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // done raises the line through either enable
  assign link.irq   = |(stat_r & en_r) || (stat_r[`ADCRS_S_DONE] && ien_r); // [R5] [R6]
  assign link.busy  = (st_r == ADCRS_CONV);
  assign link.rdata = rd_r;
  assign powered    = on_r;                       // [R8]
endmodule
`default_nettype wire

// ---- core/adcrs_params.svh ----
`ifndef ADCRS_PARAMS_SVH
`define ADCRS_PARAMS_SVH
// ----------------------------------------
// register offsets (byte registers)
// ----------------------------------------
`define ADCRS_A_CTRL    3'h0
`define ADCRS_A_CFG     3'h1
`define ADCRS_A_RESL    3'h2
`define ADCRS_A_RESH    3'h3
`define ADCRS_A_STAT    3'h4
`define ADCRS_A_CLR     3'h5
`define ADCRS_A_IEN     3'h6
// ----------------------------------------
// field positions
// ----------------------------------------
`define ADCRS_B_ON      7
`define ADCRS_B_START   6
`define ADCRS_B_DONE    4
`define ADCRS_B_LEFT    5
`define ADCRS_B_DIFF    0
`define ADCRS_S_DONE    0
`define ADCRS_S_SLEEP   1
// ----------------------------------------
// reset values and codes
// ----------------------------------------
`define ADCRS_RST_BYTE  8'h00
`define ADCRS_RST_STAT  2'h0
`define ADCRS_FULL_SE   11'h3ff
`define ADCRS_DIFF_MAX  11'h1ff
`define ADCRS_DIFF_MIN  11'h600
// ----------------------------------------
// conversion lengths in clock cycles
// ----------------------------------------
`define ADCRS_CONV_CYC  5'h0d
`define ADCRS_FIRST_CYC 5'h19
`endif

// ---- core/adcrs_pkg.sv ----
package adcrs_pkg;
  // sleep state that the core announces
  typedef enum logic [1:0] {
    ADCRS_RUN   = 2'b00,
    ADCRS_IDLE  = 2'b01,
    ADCRS_QUIET = 2'b10,
    ADCRS_OTHER = 2'b11
  } adcrs_sleep_t;
  // converter sequencer
  typedef enum logic [0:0] {
    ADCRS_WAIT = 1'b0,
    ADCRS_CONV = 1'b1
  } adcrs_conv_t;
  // core power state
  typedef enum logic [0:0] {
    ADCRS_AWAKE  = 1'b0,
    ADCRS_HALTED = 1'b1
  } adcrs_core_t;
endpackage

// ---- core/adcrs_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface adcrs_if;
  import adcrs_pkg::*;
  logic [2:0]   addr;       // register address
  logic [7:0]   wdata;      // write data
  logic         wr;         // write strobe
  logic         rd;         // read strobe
  logic [7:0]   rdata;      // read data, cycle after rd
  adcrs_sleep_t sleep_mode; // announced sleep state
  logic         halted;     // core clock stopped
  logic         irq;        // converter interrupt level
  logic         busy;       // conversion running
  modport dev (input addr, wdata, wr, rd, sleep_mode, halted, output rdata, irq, busy);
  modport cpu (output addr, wdata, wr, rd, sleep_mode, halted, input rdata, irq, busy);
endinterface
`default_nettype wire

// ---- core/adcrs_cpu.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "adcrs_params.svh"
module adcrs_cpu
  import adcrs_pkg::*;
(
  // clock and reset
  input  wire logic         clock,
  input  wire logic         rstn,
  // software register port
  input  wire logic [2:0]   sw_addr,
  input  wire logic [7:0]   sw_wdata,
  input  wire logic         sw_wr,
  input  wire logic         sw_rd,
  output logic      [7:0]   sw_rdata,
  // sleep and interrupt requests, reference change, channel choice and pin requests
  input  wire logic         sleep_req,
  input  wire adcrs_sleep_t sleep_sel,
  input  wire logic         other_irq,
  input  wire logic         ref_changed,
  input  wire logic         want_diff,
  input  wire logic [7:0]   pin_req,
  // status towards user
  output logic              core_halted,
  output logic              handler_go,
  output logic              other_go,
  output logic              result_suspect,
  output logic              recycle_advise,
  output logic      [7:0]   pin_out,
  // converter side
  adcrs_if.cpu              link
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  adcrs_core_t  st_r, st_nxt;       // power state
  adcrs_sleep_t mode_r, mode_nxt;   // current sleep state
  logic         irq_d_r, irq_d_nxt; // irq seen last cycle
  logic         hgo_r, hgo_nxt;     // handler dispatch pulse
  logic         ogo_r, ogo_nxt;     // other handler pulse
  logic         sus_r, sus_nxt;     // next result suspect
  logic         rec_r, rec_nxt;     // recycle advised
  logic [7:0]   pin_r, pin_nxt;     // held digital outputs
  logic         irq_new;            // rising converter irq

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    st_nxt    = st_r;
    mode_nxt  = mode_r;
    ogo_nxt   = 1'b0;
    rec_nxt   = rec_r;
    irq_new   = link.irq && !irq_d_r;
    irq_d_nxt = link.irq;
    hgo_nxt   = irq_new;                          // [R5] [R6]
    sus_nxt   = sus_r;
    unique case (st_r)
      ADCRS_AWAKE: begin
        // only an explicit sleep request halts again
        if (sleep_req && sleep_sel != ADCRS_RUN) begin // [R7]
          st_nxt   = ADCRS_HALTED;
          mode_nxt = sleep_sel;
        end
      end
      ADCRS_HALTED: begin
        // any interrupt wakes; other one gets its own pulse, not ordered before the handler pulse
        if (other_irq || link.irq) begin
          st_nxt   = ADCRS_AWAKE;
          mode_nxt = ADCRS_RUN;
          ogo_nxt  = other_irq;                   // [R6]
          if (mode_r == ADCRS_OTHER && want_diff) begin
            rec_nxt = 1'b1;                       // [R9]
          end
        end
      end
    endcase
    if (sw_wr && sw_addr == `ADCRS_A_CTRL && !sw_wdata[`ADCRS_B_ON]) begin
      rec_nxt = 1'b0;                             // [R9]
    end
    // first result after a reference change is flagged
    if (ref_changed) begin
      sus_nxt = 1'b1;                             // [R2]
    end else if (irq_new) begin
      sus_nxt = 1'b0;                             // [R2]
    end
    // digital pins frozen while converting
    pin_nxt = link.busy ? pin_r : pin_req;        // [R10]
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_r    <= ADCRS_AWAKE;
      mode_r  <= ADCRS_RUN;
      irq_d_r <= 1'b0;
      hgo_r   <= 1'b0;
      ogo_r   <= 1'b0;
      sus_r   <= 1'b0;
      rec_r   <= 1'b0;
      pin_r   <= `ADCRS_RST_BYTE;
    end else begin
      st_r    <= st_nxt;
      mode_r  <= mode_nxt;
      irq_d_r <= irq_d_nxt;
      hgo_r   <= hgo_nxt;
      ogo_r   <= ogo_nxt;
      sus_r   <= sus_nxt;
      rec_r   <= rec_nxt;
      pin_r   <= pin_nxt;
    end
  end

  // ----------------------------------------
  // outputs and link
  // ----------------------------------------
  assign link.addr       = sw_addr;
  assign link.wdata      = sw_wdata;
  assign link.wr         = sw_wr;
  assign link.rd         = sw_rd;
  assign link.sleep_mode = mode_r;
  assign link.halted     = (st_r == ADCRS_HALTED);
  assign sw_rdata        = link.rdata;
  assign core_halted     = (st_r == ADCRS_HALTED);
  assign handler_go      = hgo_r;
  assign other_go        = ogo_r;
  assign result_suspect  = sus_r;
  assign recycle_advise  = rec_r;
  assign pin_out         = pin_r;
endmodule
`default_nettype wire

// ---- dv/adcrs_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module adcrs_assertions
  import adcrs_pkg::*;
(
  // clock and reset
  input wire logic         clock,
  input wire logic         rstn,
  // interface signals
  input wire logic [2:0]   addr,
  input wire logic [7:0]   wdata,
  input wire logic         wr,
  input wire logic         rd,
  input wire logic [7:0]   rdata,
  input wire adcrs_sleep_t sleep_mode,
  input wire logic         halted,
  input wire logic         irq,
  input wire logic         busy
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // ----------------------------------------
  // shadows of written bits, busy length
  // ----------------------------------------
  logic       on_r;  // converter switched on
  logic       lft_r; // left alignment chosen
  logic       ien_r; // done interrupt enabled
  logic [7:0] cnt_r; // cycles busy has stood
  logic       abt;   // write that switches the converter off
  assign abt = wr && addr == 3'h0 && !wdata[7];
  // track writes and count busy cycles
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      on_r  <= 1'b0;
      lft_r <= 1'b0;
      ien_r <= 1'b0;
      cnt_r <= 8'h00;
    end else begin
      on_r  <= (wr && addr == 3'h0) ? wdata[7] : on_r;
      lft_r <= (wr && addr == 3'h1) ? wdata[5] : lft_r;
      ien_r <= (wr && addr == 3'h6) ? wdata[0] : ien_r;
      cnt_r <= busy ? cnt_r + 8'h01 : 8'h00;
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_rd_quiet;
    !$past(rd) |-> rdata == 8'h00;
  endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("read data not zero outside a read");
  property p_sleep_start;
    $rose(halted) && on_r && !busy && sleep_mode inside {ADCRS_IDLE, ADCRS_QUIET} |=> busy;
  endproperty
  a_sleep_start: assert property (p_sleep_start) else $error("halt did not start a conversion");
  property p_other_quiet;
    $rose(halted) && sleep_mode == ADCRS_OTHER && !busy |=> !busy;
  endproperty
  a_other_quiet: assert property (p_other_quiet) else $error("conversion started in other sleep");
  property p_conv_len;
    $fell(busy) && !$past(abt) |-> cnt_r == 8'h0d || cnt_r == 8'h19;
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");
  property p_done_irq;
    $fell(busy) && !$past(abt) && ien_r |-> irq;
  endproperty
  a_done_irq: assert property (p_done_irq) else $error("no interrupt at conversion end");
  property p_irq_wake;
    halted && irq |=> !halted;
  endproperty
  a_irq_wake: assert property (p_irq_wake) else $error("interrupt did not wake the core");
  property p_stay_awake;
    $fell(halted) |=> !halted [*2];
  endproperty
  a_stay_awake: assert property (p_stay_awake) else $error("core slept again at once");
  property p_left_low;
    rd && addr == 3'h2 && lft_r |=> rdata[5:0] == 6'h00;
  endproperty
  a_left_low: assert property (p_left_low) else $error("left low byte spare bits set");
  property p_right_high;
    rd && addr == 3'h3 && !lft_r |=> rdata[7:2] == 6'h00;
  endproperty
  a_right_high: assert property (p_right_high) else $error("right high byte spare bits set");
  // main scenarios reached
  c_sleep_conv: cover property ($rose(halted) ##1 busy);
  c_wake: cover property (halted ##1 !halted);
  c_left: cover property (rd && addr == 3'h2 && lft_r);
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import adcrs_pkg::*;
;
  logic         clock, rstn, sw_wr, sw_rd, sleep_req, other_irq, ref_changed, want_diff;
  logic         core_halted, handler_go, other_go, result_suspect, recycle_advise, powered;
  logic [2:0]   sw_addr;
  logic [7:0]   sw_wdata, sw_rdata, pin_req, pin_out;
  logic [10:0]  sample_se, sample_diff;
  adcrs_sleep_t sleep_sel;
  int           mismatches, n_compared;
  // ----------------------------------------
  // both ends and the checker
  // ----------------------------------------
  adcrs_if adcrs_if_inst ();
  adcrs_cpu adcrs_cpu_inst (.clock(clock), .rstn(rstn), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
    .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .sleep_req(sleep_req), .sleep_sel(sleep_sel),
    .other_irq(other_irq), .ref_changed(ref_changed), .want_diff(want_diff), .pin_req(pin_req),
    .core_halted(core_halted), .handler_go(handler_go), .other_go(other_go),
    .result_suspect(result_suspect), .recycle_advise(recycle_advise), .pin_out(pin_out),
    .link(adcrs_if_inst));
  adcrs_dev adcrs_dev_inst (.clock(clock), .rstn(rstn), .sample_se(sample_se),
    .sample_diff(sample_diff), .powered(powered), .link(adcrs_if_inst));
  adcrs_assertions adcrs_assertions_inst (.clock(clock), .rstn(rstn), .addr(adcrs_if_inst.addr),
    .wdata(adcrs_if_inst.wdata), .wr(adcrs_if_inst.wr), .rd(adcrs_if_inst.rd),
    .rdata(adcrs_if_inst.rdata), .sleep_mode(adcrs_if_inst.sleep_mode),
    .halted(adcrs_if_inst.halted), .irq(adcrs_if_inst.irq), .busy(adcrs_if_inst.busy));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // one-cycle write strobe
  task automatic wr_reg(logic [2:0] a, logic [7:0] d);
    @(posedge clock);
    sw_wr <= 1'b1;
    sw_addr <= a;
    sw_wdata <= d;
    @(posedge clock);
    sw_wr <= 1'b0;
  endtask
  // one-cycle read strobe, data taken at the edge that closes the cycle after
  task automatic rd_reg(logic [2:0] a, output logic [7:0] d);
    @(posedge clock);
    sw_rd <= 1'b1;
    sw_addr <= a;
    @(posedge clock);
    sw_rd <= 1'b0;
    @(posedge clock);
    d = sw_rdata;
  endtask
  // both result bytes against the expected layout
  task automatic chk_res(logic lft, logic [9:0] code);
    logic [7:0] lo, hi;
    rd_reg(3'h2, lo);
    rd_reg(3'h3, hi);
    chk("result", {hi, lo}, lft ? {code, 6'h00} : {6'h00, code});
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // software start, then alignment flipped after the result is in
  task automatic t_convert(logic lft, logic dif, logic [10:0] se, logic [10:0] df, logic [9:0] code);
    logic [7:0] st;
    sample_se <= se;
    sample_diff <= df;
    wr_reg(3'h1, {2'b00, lft, 4'h0, dif});
    wr_reg(3'h0, 8'hc0);
    repeat (2) @(posedge clock);
    for (int i = 0; i < 40 && adcrs_if_inst.busy === 1'b1; i++) @(posedge clock);
    rd_reg(3'h4, st);
    chk("done", st[0], 1'b1);
    chk_res(lft, code);
    wr_reg(3'h1, {2'b00, !lft, 4'h0, dif});
    chk_res(!lft, code);
    wr_reg(3'h5, 8'h03);
  endtask
  // sleep conversion, optionally woken early by another interrupt
  task automatic t_sleep(adcrs_sleep_t m, logic oth);
    logic [7:0] p;
    logic [7:0] st;
    logic       hg, og;
    hg = 1'b0;
    og = 1'b0;
    p = pin_out;
    wr_reg(3'h0, 8'h80);
    wr_reg(3'h1, 8'h00);
    wr_reg(3'h6, 8'h01);
    @(posedge clock);
    sleep_req <= 1'b1;
    sleep_sel <= m;
    @(posedge clock);
    sleep_req <= 1'b0;
    // values read at an edge are those launched by the edge before
    for (int i = 0; i < 60; i++) begin
      @(posedge clock);
      other_irq <= oth && i == 4;
      if (adcrs_if_inst.busy === 1'b1 && i < 3) begin
        p = pin_out;
        pin_req <= ~pin_req;
      end
      if (adcrs_if_inst.busy === 1'b1) chk("pins", pin_out, p);
      hg |= handler_go === 1'b1;
      og |= other_go === 1'b1;
    end
    chk("handler", hg, 1'b1);
    chk("other", og, oth);
    chk("halted", core_halted, 1'b0);
    chk("irq", adcrs_if_inst.irq, 1'b1);
    chk("suspect clear", result_suspect, 1'b0);
    rd_reg(3'h4, st);
    chk("sleep start", st[1:0], 2'h3);
    chk_res(1'b0, sample_se[9:0]);
    wr_reg(3'h5, 8'h03);
    @(posedge clock);
    chk("irq clear", adcrs_if_inst.irq, 1'b0);
  endtask
  // deeper sleep: converter stays on, no automatic start; recycle afterwards
  task automatic t_other();
    int n;
    want_diff <= 1'b1;
    @(posedge clock);
    sleep_req <= 1'b1;
    sleep_sel <= ADCRS_OTHER;
    @(posedge clock);
    sleep_req <= 1'b0;
    repeat (20) @(posedge clock);
    chk("no start", adcrs_if_inst.busy, 1'b0);
    chk("powered", powered, 1'b1);
    chk("asleep", core_halted, 1'b1);
    other_irq <= 1'b1;
    repeat (3) @(posedge clock);
    other_irq <= 1'b0;
    chk("woken", core_halted, 1'b0);
    chk("recycle", recycle_advise, 1'b1);
    wr_reg(3'h0, 8'h00);
    wr_reg(3'h0, 8'hc0);
    chk("recycle off", recycle_advise, 1'b0);
    // count edges until busy is seen low: 25 busy cycles plus one
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (adcrs_if_inst.busy === 1'b1 && n < 40);
    chk("extended", 16'(n), 16'h001a);
  endtask
  // ----------------------------------------
  // clock, sequence, watchdog
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial begin
    {rstn, sw_wr, sw_rd, sleep_req, other_irq, ref_changed, want_diff} = 7'h00;
    {sw_addr, sw_wdata, pin_req, sample_se, sample_diff} = 41'h0;
    sleep_sel = ADCRS_RUN;
    mismatches = 0;
    n_compared = 0;
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    ref_changed <= 1'b1;
    @(posedge clock);
    ref_changed <= 1'b0;
    repeat (2) @(posedge clock);
    chk("suspect", result_suspect, 1'b1);
    t_convert(1'b0, 1'b0, 11'h123, 11'h000, 10'h123);
    t_convert(1'b1, 1'b0, 11'h5ff, 11'h000, 10'h3ff);
    t_convert(1'b1, 1'b1, 11'h000, 11'h670, 10'h270);
    t_convert(1'b0, 1'b1, 11'h000, 11'h300, 10'h1ff);
    t_convert(1'b0, 1'b1, 11'h000, 11'h400, 10'h200);
    sample_se <= 11'h2a5;
    t_sleep(ADCRS_QUIET, 1'b0);
    t_sleep(ADCRS_IDLE, 1'b1);
    t_other();
    print_verdict();
  end
  initial begin
    #100000;
    mismatches++;
    print_verdict();
  end
endmodule
`default_nettype wire
